// ==== pkg/adc_seq_pkg.sv ====
/*
  shared constants and types of the converter sequencer.
  assumes an ahb-lite slave of 32-bit words and a 200 MHz hclk.
*/
package adc_seq_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] off_mode_zero = 8'h00;
  localparam logic [7:0] off_mode_one = 8'h04;
  localparam logic [7:0] off_chan_sel = 8'h08;
  localparam logic [7:0] off_result = 8'h0c;
  localparam logic [7:0] off_result_high = 8'h10;
  localparam logic [7:0] off_status = 8'h14;
  // ==========================================================
  // field positions in converter_mode_reg_zero
  localparam int bit_power_on = 0;
  localparam int bit_run = 1;
  localparam int bit_wait_mode = 2;
  localparam int bit_scan_mode = 3;
  localparam int bit_one_shot = 4;
  // trigger-source field in converter_mode_reg_one
  localparam int trig_src_lsb = 0;
  localparam int trig_src_w = 2;
  // ==========================================================
  // timing
  localparam int clk_mhz = 200;
  localparam int stab_time_ns = 1000;
  localparam int stab_cycles = (stab_time_ns * clk_mhz + 999) / 1000;
  localparam int conv_cycles_dflt = 32;
  localparam int scan_slots = 4;
  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {
    st_stop,
    st_conv_standby,
    st_trig_standby,
    st_converting
  } seq_state_t;
endpackage

// ==== pkg/result_if.sv ====
/*
  carrier between the sequencer and its result store.
  assumes one writer and one reader on hclk.
*/
`timescale 1ns/1ps
interface result_if #(parameter int width = 10);
  logic wr_en;
  logic [width-1:0] wr_data;
  logic [width-1:0] rd_data;
  modport writer (output wr_en, output wr_data, input rd_data);
  modport store (input wr_en, input wr_data, output rd_data);
endinterface

// ==== hw/result_store.sv ====
/*
  holds the last conversion result in a register.
  assumes writes come one per conversion end.
*/
`timescale 1ns/1ps
module result_store #(
  parameter int width = 10
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // result carrier
  result_if.store res
);
  typedef struct packed {
    logic [width-1:0] data;
  } store_t;
  store_t s_q, s_d;
  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    if (res.wr_en) begin
      s_d.data = res.wr_data;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign res.rd_data = s_q.data;
endmodule // result_store

// ==== hw/adc_hw_trigger_sequencer.sv ====
/*
  hardware-triggered sequencer of a successive-approximation converter,
  with its registers on ahb-lite.
  assumes the analog core converts while conv_active is high and hands
  back a sample with conv_data; triggers are one-cycle pulses on hclk.
*/
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
// Contract
// R1: no-wait: power on goes to conversion standby
// R2: software waits stabilisation before setting run
// R3: no-wait run only arms trigger standby
// R4: scan converts slots zero to three
// R5: each end stores result, pulses done irq
// R6: no-wait scan one-shot keeps run, standby
// R7: scan trigger mid-conversion restarts slot zero
// R8: channel write mid-conversion restarts conversion
// R9: run write one mid-conversion restarts
// R10: no-wait run clear aborts to standby
// R11: power off stops; no-wait triggers ignored without run
// R12: wait mode power on enters trigger standby
// R13: wait trigger sets run and starts
// R14: wait select sequential chains conversions
// R15: wait one-shot clears run and stops
// R16: wait scan sequential restarts scan
// R17: wait run clear aborts, stops converter
// R18: wait mode ignores triggers without power
// R19: select converts only the selected input
// R20: software picks trigger source in mode one
// R21: mode bits sampled at each decision
module adc_hw_trigger_sequencer #(
  parameter int res_width = 10,
  parameter int chan_width = 5,
  parameter int conv_cycles = adc_seq_pkg::conv_cycles_dflt
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // hardware trigger sources
  input wire logic [3:0] trig_events,
  // analog core
  output logic conv_active,
  output logic conv_abort,
  output logic [chan_width-1:0] conv_channel,
  input wire logic [res_width-1:0] conv_data,
  output logic converter_powered,
  // interrupt request
  output logic conversion_done_irq
);
  initial begin
    if (res_width < 1 || res_width > 16 || chan_width < 1 || chan_width > 8 ||
        conv_cycles < 2 || conv_cycles > 65535) begin
      $error("adc_hw_trigger_sequencer: unsupported parameter");
    end
  end

  typedef struct packed {
    adc_seq_pkg::seq_state_t st;
    logic power_on;
    logic run;
    logic wait_mode;
    logic scan_mode;
    logic one_shot;
    logic [adc_seq_pkg::trig_src_w-1:0] trig_src;
    logic [chan_width-1:0] chan_sel;
    logic [1:0] slot;
    logic [15:0] cnt;
    logic done;
    logic abort;
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
  } seq_t;

  seq_t s_q, s_d;
  result_if #(.width(res_width)) res ();

  result_store #(.width(res_width)) u_store (
    .hclk(hclk),
    .hresetn(hresetn),
    .res(res)
  );

  // ==========================================================
  // helpers
  function automatic logic [chan_width-1:0] slot_chan(input logic [chan_width-1:0] base,
                                                      input logic [1:0] slot,
                                                      input logic scan);
    slot_chan = scan ? base + chan_width'(slot) : base;
  endfunction

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    addr_is = (a == off);
  endfunction

  logic trig;
  logic wr_now;
  logic wr_zero;
  logic wr_chan;
  logic conv_end;
  logic [31:0] wd;
  logic new_run;
  logic new_power;

  assign trig = trig_events[s_q.trig_src];
  assign wd = hwdata;
  assign wr_now = s_q.ph_valid && s_q.ph_write;
  assign wr_zero = wr_now && addr_is(s_q.ph_addr, adc_seq_pkg::off_mode_zero);
  assign wr_chan = wr_now && addr_is(s_q.ph_addr, adc_seq_pkg::off_chan_sel);
  assign conv_end = (s_q.st == adc_seq_pkg::st_converting) &&
                    (s_q.cnt == 16'(conv_cycles - 1));
  assign new_run = wd[adc_seq_pkg::bit_run];
  assign new_power = wd[adc_seq_pkg::bit_power_on];

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.abort = 1'b0;
    // bus address phase
    s_d.ph_valid = hsel && hready && htrans[1];
    s_d.ph_write = hwrite;
    s_d.ph_addr = haddr[7:0];
    if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        adc_seq_pkg::off_mode_zero: s_d.rdata = 32'({s_q.one_shot, s_q.scan_mode,
                                                     s_q.wait_mode, s_q.run, s_q.power_on});
        adc_seq_pkg::off_mode_one: s_d.rdata = 32'(s_q.trig_src);
        adc_seq_pkg::off_chan_sel: s_d.rdata = 32'(s_q.chan_sel);
        adc_seq_pkg::off_result: s_d.rdata = 32'(res.rd_data);
        adc_seq_pkg::off_result_high: s_d.rdata = 32'(res.rd_data >> 8);
        adc_seq_pkg::off_status: s_d.rdata = {28'h0000000, s_q.slot, s_q.st};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
    // conversion timing
    if (s_q.st == adc_seq_pkg::st_converting) begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
    // conversion end and its follow-up
    if (conv_end) begin
      s_d.done = 1'b1; // see R5
      s_d.cnt = '0;
      if (s_q.scan_mode && s_q.slot != 2'(adc_seq_pkg::scan_slots - 1)) begin
        s_d.slot = s_q.slot + 2'h1; // see R4
      end else begin
        s_d.slot = '0;
        if (!s_q.one_shot) begin
          s_d.st = adc_seq_pkg::st_converting; // see R14 see R16
        end else if (s_q.wait_mode) begin
          s_d.run = 1'b0; // see R15
          s_d.st = adc_seq_pkg::st_stop;
        end else begin
          s_d.st = adc_seq_pkg::st_conv_standby; // see R6
        end
      end
    end
    // hardware trigger, qualified by power, and by run only for a no-wait start from standby
    if (trig && s_q.power_on) begin // see R18
      if (s_q.wait_mode && s_q.st == adc_seq_pkg::st_trig_standby) begin
        s_d.run = 1'b1; // see R13
        s_d.st = adc_seq_pkg::st_converting;
        s_d.slot = '0;
        s_d.cnt = '0;
      end else if (s_q.run && !s_q.wait_mode &&
                   (s_q.st == adc_seq_pkg::st_trig_standby ||
                    s_q.st == adc_seq_pkg::st_conv_standby)) begin
        s_d.st = adc_seq_pkg::st_converting; // see R11
        s_d.slot = '0;
        s_d.cnt = '0;
      end else if (s_q.st == adc_seq_pkg::st_converting) begin
        s_d.abort = 1'b1; // see R7
        s_d.done = 1'b0;
        s_d.st = adc_seq_pkg::st_converting;
        s_d.slot = '0;
        s_d.cnt = '0;
      end
    end
    // register writes
    if (wr_chan) begin
      s_d.chan_sel = wd[chan_width-1:0];
      if (s_q.st == adc_seq_pkg::st_converting) begin
        s_d.abort = 1'b1; // see R8
        s_d.done = 1'b0;
        s_d.st = adc_seq_pkg::st_converting;
        s_d.slot = '0;
        s_d.cnt = '0;
      end
    end
    if (wr_now && addr_is(s_q.ph_addr, adc_seq_pkg::off_mode_one)) begin
      s_d.trig_src = wd[adc_seq_pkg::trig_src_lsb +: adc_seq_pkg::trig_src_w]; // see R20
    end
    if (wr_zero) begin
      s_d.wait_mode = wd[adc_seq_pkg::bit_wait_mode]; // see R21
      s_d.scan_mode = wd[adc_seq_pkg::bit_scan_mode];
      s_d.one_shot = wd[adc_seq_pkg::bit_one_shot];
      s_d.power_on = new_power;
      s_d.run = new_run && new_power;
      if (!new_power) begin
        s_d.run = 1'b0;
        s_d.st = adc_seq_pkg::st_stop; // see R11
        s_d.abort = (s_q.st == adc_seq_pkg::st_converting);
        s_d.done = 1'b0;
      end else if (s_q.st == adc_seq_pkg::st_stop) begin
        s_d.run = 1'b0;
        s_d.st = wd[adc_seq_pkg::bit_wait_mode] ? adc_seq_pkg::st_trig_standby // see R12
                                                : adc_seq_pkg::st_conv_standby; // see R1
      end else if (s_q.st == adc_seq_pkg::st_converting) begin
        s_d.done = 1'b0;
        s_d.abort = 1'b1;
        s_d.slot = '0;
        s_d.cnt = '0;
        if (new_run) begin
          s_d.st = adc_seq_pkg::st_converting; // see R9
        end else if (s_q.wait_mode) begin
          s_d.st = adc_seq_pkg::st_trig_standby; // see R17
          s_d.power_on = 1'b0;
        end else begin
          s_d.st = adc_seq_pkg::st_conv_standby; // see R10
        end
      end else if (!s_q.wait_mode) begin
        // run arms trigger standby, run clear falls back to conversion standby
        s_d.st = new_run ? adc_seq_pkg::st_trig_standby // see R3
                         : adc_seq_pkg::st_conv_standby; // see R10
      end else begin
        s_d.run = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{st: adc_seq_pkg::st_stop, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  // store takes the sample at the edge ending the conversion, before the slot moves on
  assign res.wr_en = s_d.done;
  assign res.wr_data = conv_data;
  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign conv_active = (s_q.st == adc_seq_pkg::st_converting);
  assign conv_abort = s_q.abort;
  assign conv_channel = slot_chan(s_q.chan_sel, s_q.slot, s_q.scan_mode); // see R19
  assign converter_powered = s_q.power_on;
  assign conversion_done_irq = s_q.done; // see R5
endmodule // adc_hw_trigger_sequencer

// ==== dv/adc_seq_assertions.sv ====
/*
  concurrent checks on the sequencer's top ports.
  assumes a single hclk domain and active-low hresetn.
*/
`timescale 1ns/1ps
module adc_seq_assertions (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // watched outputs
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic conv_active,
  input wire logic conv_abort,
  input wire logic converter_powered,
  input wire logic conversion_done_irq
);
  // ==========================================================
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_READY: assert property (hreadyout) else $error("slave not ready");
  AST_OKAY: assert property (!hresp) else $error("slave response not okay");
  AST_IRQ_PULSE: assert property (conversion_done_irq |=> !conversion_done_irq)
    else $error("done irq longer than one cycle");
  AST_IRQ_CAUSE: assert property ($rose(conversion_done_irq) |-> $past(conv_active))
    else $error("done irq without conversion");
  AST_ABORT_CAUSE: assert property (conv_abort |-> $past(conv_active))
    else $error("abort outside conversion");
  AST_ABORT_NO_IRQ: assert property (conv_abort |-> !conversion_done_irq)
    else $error("aborted conversion reported done");
  AST_OFF_IDLE: assert property (!converter_powered && !$past(converter_powered)
    |-> !conv_active) else $error("converting while unpowered");
  AST_START_POWERED: assert property ($rose(conv_active) |-> converter_powered)
    else $error("conversion started unpowered");
  // ==========================================================
  // main scenarios
  cover property ($rose(conversion_done_irq));
  cover property (conv_abort);
  cover property ($fell(converter_powered));
endmodule // adc_seq_assertions

bind adc_hw_trigger_sequencer adc_seq_assertions adc_seq_assertions_inst (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .conv_active(conv_active), .conv_abort(conv_abort),
  .converter_powered(converter_powered), .conversion_done_irq(conversion_done_irq));

// ==== dv/adc_core_model.sv ====
/*
  behavioural analog core: a sample names its channel.
  assumes the sequencer captures conv_data while converting.
*/
`timescale 1ns/1ps
module adc_core_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // sequencer side
  input wire logic conv_active,
  input wire logic [4:0] conv_channel,
  output logic [9:0] conv_data
);
  // ==========================================================
  // sample or changing junk when idle
  logic [9:0] junk_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) junk_q <= 10'h000;
    else junk_q <= junk_q + 10'h001;
  end
  assign conv_data = conv_active ? {conv_channel, ~conv_channel} : junk_q;
endmodule // adc_core_model

// ==== dv/adc_hw_trigger_sequencer_bench.sv ====
/*
  directed bench of the sequencer over ahb-lite.
  assumes a zero-wait slave and a short conversion count.
*/
`timescale 1ns/1ps
module adc_hw_trigger_sequencer_bench;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, conv_active, conv_abort;
  logic converter_powered, conversion_done_irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] trig_events;
  logic [4:0] conv_channel;
  logic [9:0] conv_data;
  int n_mismatch, checked, k;
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  adc_hw_trigger_sequencer #(.conv_cycles(8)) adc_hw_trigger_sequencer_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .trig_events(trig_events),
    .conv_active(conv_active), .conv_abort(conv_abort), .conv_channel(conv_channel),
    .conv_data(conv_data), .converter_powered(converter_powered),
    .conversion_done_irq(conversion_done_irq));
  adc_core_model adc_core_model_inst (.hclk(hclk), .hresetn(hresetn),
    .conv_active(conv_active), .conv_channel(conv_channel), .conv_data(conv_data));
  // ==========================================================
  // tasks
  function automatic logic [31:0] smp(input logic [4:0] c);
    return {22'h0, c, ~c};
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xf(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic trg(input int b);
    trig_events <= 4'h1 << b;
    @(posedge hclk);
    trig_events <= 4'h0;
  endtask
  task automatic wi();
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (conversion_done_irq !== 1'b1 && k < 200);
    chk(32'(k < 200), 32'h1);
  endtask
  task automatic ni(input int n);
    k = 0;
    repeat (n) begin
      @(posedge hclk);
      if (conversion_done_irq !== 1'b0 || conv_active !== 1'b0) k++;
    end
    chk(32'(k), 32'h0);
  endtask
  task automatic complete_run();
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #50000;
    n_mismatch++;
    complete_run();
  end
  // ==========================================================
  // scenarios
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; trig_events = 4'h0; n_mismatch = 0; checked = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(8'h14, 32'hf, 32'h0);
    rc(8'h18, 32'hffffffff, 32'h0);
    xf(1'b1, 8'h08, 32'h4);
    xf(1'b1, 8'h00, 32'h19);
    trg(0);
    rc(8'h14, 32'h3, 32'h1);
    ni(12);
    repeat (adc_seq_pkg::stab_cycles) @(posedge hclk);
    xf(1'b1, 8'h00, 32'h1b);
    rc(8'h14, 32'h3, 32'h2);
    ni(12);
    trg(0);
    for (int i = 0; i < 4; i++) begin
      wi();
      rc(8'h0c, 32'h3ff, smp(5'(4 + i)));
    end
    rc(8'h10, 32'hffffffff, smp(5'h7) >> 8);
    rc(8'h00, 32'h2, 32'h2);
    rc(8'h14, 32'h3, 32'h1);
    xf(1'b1, 8'h00, 32'h1b);
    trg(0);
    wi();
    repeat (3) @(posedge hclk);
    trg(0);
    wi();
    rc(8'h0c, 32'h3ff, smp(5'h4));
    xf(1'b1, 8'h08, 32'h10);
    wi();
    rc(8'h0c, 32'h3ff, smp(5'h10));
    xf(1'b1, 8'h00, 32'h1b);
    wi();
    rc(8'h0c, 32'h3ff, smp(5'h10));
    xf(1'b1, 8'h00, 32'h19);
    rc(8'h14, 32'h3, 32'h1);
    chk(32'(converter_powered), 32'h1);
    ni(20);
    xf(1'b1, 8'h00, 32'h18);
    rc(8'h14, 32'h3, 32'h0);
    trg(0);
    ni(20);
    xf(1'b1, 8'h08, 32'h2);
    xf(1'b1, 8'h00, 32'h05);
    rc(8'h14, 32'h3, 32'h2);
    trg(0);
    rc(8'h00, 32'h2, 32'h2);
    wi();
    rc(8'h0c, 32'h3ff, smp(5'h2));
    wi();
    xf(1'b1, 8'h00, 32'h05);
    repeat (2) @(posedge hclk);
    chk(32'(converter_powered), 32'h0);
    trg(0);
    ni(20);
    xf(1'b1, 8'h04, 32'h1);
    xf(1'b1, 8'h00, 32'h15);
    trg(0);
    ni(20);
    trg(1);
    wi();
    repeat (2) @(posedge hclk);
    rc(8'h00, 32'h2, 32'h0);
    rc(8'h14, 32'h3, 32'h0);
    xf(1'b1, 8'h08, 32'h4);
    xf(1'b1, 8'h00, 32'h0d);
    trg(1);
    repeat (5) wi();
    rc(8'h0c, 32'h3ff, smp(5'h4));
    complete_run();
  end
endmodule // adc_hw_trigger_sequencer_bench
